// *** src/gtcd_cfg.svh ***
// Constants for the bus command decoder of the tape drive
//
// Function
// - Remote enable line is ignored; it changes nothing.
// - Secondary byte follows a primary byte under attention, any value 96 or above.
// - In host command mode, secondaries after own address select tape commands.
// - In verb command mode, every secondary byte is disregarded.
// - Universal commands are 0-31, 63, 95; act on untalk, unlisten, poll enable/disable.
// - Unlisten (63) ends a data string; only then the input buffer is parsed.
// - Untalk (95) under attention stops an addressed talker.
// - Once unaddressed, data bytes are ignored until the own listen address is received again.
// - Poll enable enters serial poll state, poll disable leaves it.
// - Service request is signalled by asserting the service request line.
// - Checksum of first 256 bytes compared to trailing byte; mismatch rereads.
// - After ten failed reads of a record, raise a service request.
// - Every checksum mismatch increments the read-error tally, recovered or not.
// - Secondary 24 takes and clears the tally at once, then talks the taken value out as ASCII digits.
// - Secondary 4 sends the stored program; both load statements use it.
// - Secondary 2 closes the file by writing an end-of-file mark.
// - Secondary 30 returns last error code as ASCII, clears error and request.
// - Secondary 27 with file number positions tape at that file.
// - Secondary 9 talks out the current file header string.
// - Secondary 13 sends the file as ASCII, records split by carriage return.
// - End-of-file mark is the single byte ff.
// - Listen address is 32 to 62, from the switch device number.
// - Talk address is 64 to 94, from the switch device number.
`ifndef GTCD_CFG_SVH
`define GTCD_CFG_SVH

`define GTCD_LAD_BASE 8'h20
`define GTCD_TAD_BASE 8'h40
`define GTCD_SEC_BASE 8'h60
`define GTCD_UNL 8'h3f
`define GTCD_UNT 8'h5f
`define GTCD_SPE 8'h18
`define GTCD_SPD 8'h19
`define GTCD_EOF_MARK 8'hff
`define GTCD_CR 8'h0d
`define GTCD_ASCII_0 8'h30
`define GTCD_CHK_BYTES 9'h100
`define GTCD_MAX_TRIES 4'ha
`define GTCD_DIG_TOP 3'h4
`define GTCD_SA_CLOSE 5'h02
`define GTCD_SA_PROG 5'h04
`define GTCD_SA_HEADER 5'h09
`define GTCD_SA_INPUT 5'h0d
`define GTCD_SA_ERRORS 5'h18
`define GTCD_SA_FIND 5'h1b
`define GTCD_SA_ERROR 5'h1e

`endif

// *** src/gtcd_decoder.sv ***
// Bus command decoder with serial poll, service request and read-error tally
`timescale 1ns/1ps
`default_nettype none
`include "gtcd_cfg.svh"

module gtcd_decoder (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [4:0] dev_addr_i,
	input wire logic host_mode_i,
	input wire logic ren_i,
	input wire logic byte_stb_i,
	input wire logic [7:0] byte_i,
	input wire logic atn_i,
	input wire logic rec_done_i,
	input wire logic [7:0] rec_sum_i,
	input wire logic [7:0] rec_chk_i,
	input wire logic [7:0] err_code_i,
	input wire logic err_set_i,
	input wire logic tx_ready_i,
	output logic listen_o,
	output logic talk_o,
	output logic spoll_o,
	output logic srq_o,
	output logic reread_o,
	output logic parse_o,
	output logic data_stb_o,
	output logic [7:0] data_o,
	output gtcd_pkg::gtcd_cmd_type cmd_o,
	output logic cmd_stb_o,
	output logic eof_wr_o,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic [15:0] tally_o
);
	import gtcd_pkg::*;

	// ----------------------------------------
	// Address and command decode
	// ----------------------------------------
	logic listen_reg, listen_next, talk_reg, talk_next, spoll_reg, spoll_next;
	logic prim_reg, prim_next, srq_reg, srq_next, reread_reg, reread_next;
	logic parse_reg, parse_next, dstb_reg, dstb_next, cstb_reg, cstb_next;
	logic eof_reg, eof_next;
	logic [7:0] data_reg, data_next;
	gtcd_cmd_type cmd_reg, cmd_next;
	logic [3:0] tries_reg, tries_next;
	logic [15:0] tally_reg, tally_next;
	logic [7:0] err_reg, err_next;
	gtcd_tx_type tx_reg, tx_next;
	logic [15:0] txval_reg, txval_next;
	logic [7:0] txb_reg, txb_next;
	logic txv_reg, txv_next, lead_reg, lead_next, untalk_now;
	logic [2:0] txidx_reg, txidx_next;
	logic [15:0] pow_q, dig_q, rem_q;
	logic [7:0] mla, mta, sa_byte;
	logic sec_byte, own_sec, bad_sum;

	// Own addresses from the switch number; ren_i is deliberately unused
	assign mla = `GTCD_LAD_BASE | {3'h0, dev_addr_i};
	assign mta = `GTCD_TAD_BASE | {3'h0, dev_addr_i};
	assign sec_byte = byte_i >= `GTCD_SEC_BASE;
	assign own_sec = atn_i && byte_stb_i && sec_byte && prim_reg && host_mode_i;
	assign sa_byte = byte_i - `GTCD_SEC_BASE;
	assign bad_sum = rec_done_i && (rec_sum_i != rec_chk_i);
	assign dig_q = txval_reg / pow_q;
	assign rem_q = txval_reg % pow_q;
	assign untalk_now = byte_stb_i && atn_i && byte_i == `GTCD_UNT;

	// Place value of the digit being talked, highest first
	always_comb begin
		case (txidx_reg)
			3'h4: pow_q = 16'h2710;
			3'h3: pow_q = 16'h03e8;
			3'h2: pow_q = 16'h0064;
			3'h1: pow_q = 16'h000a;
			default: pow_q = 16'h0001;
		endcase
	end

	// Next state of the decoder
	always_comb begin
		listen_next = listen_reg;
		talk_next = talk_reg;
		spoll_next = spoll_reg;
		prim_next = prim_reg;
		srq_next = srq_reg;
		reread_next = 1'b0;
		parse_next = 1'b0;
		dstb_next = 1'b0;
		data_next = data_reg;
		cstb_next = 1'b0;
		cmd_next = cmd_reg;
		eof_next = 1'b0;
		tries_next = tries_reg;
		tally_next = tally_reg;
		err_next = err_reg;
		tx_next = tx_reg;
		txval_next = txval_reg;
		txb_next = txb_reg;
		txv_next = txv_reg;
		txidx_next = txidx_reg;
		lead_next = lead_reg;
		if (byte_stb_i && atn_i) begin
			prim_next = 1'b0;
			if (byte_i == `GTCD_UNL) begin
				if (listen_reg)
					parse_next = 1'b1;
				listen_next = 1'b0;
			end else if (byte_i == `GTCD_UNT) begin
				talk_next = 1'b0;
				tx_next = GTCD_TX_IDLE;
				txv_next = 1'b0;
			end else if (byte_i == `GTCD_SPE)
				spoll_next = 1'b1;
			else if (byte_i == `GTCD_SPD)
				spoll_next = 1'b0;
			else if (byte_i == mla) begin
				listen_next = 1'b1;
				prim_next = 1'b1;
			end else if (byte_i == mta) begin
				talk_next = 1'b1;
				prim_next = 1'b1;
			end else if (own_sec) begin
				cstb_next = 1'b1;
				case (sa_byte[4:0])
					`GTCD_SA_CLOSE: begin
						cmd_next = GTCD_CMD_CLOSE;
						eof_next = 1'b1;
					end
					`GTCD_SA_PROG: cmd_next = GTCD_CMD_PROGRAM_READOUT;
					`GTCD_SA_HEADER: cmd_next = GTCD_CMD_HEADER;
					`GTCD_SA_INPUT: cmd_next = GTCD_CMD_INPUT;
					`GTCD_SA_FIND: cmd_next = GTCD_CMD_FIND;
					`GTCD_SA_ERRORS: begin
						cmd_next = GTCD_CMD_OTHER;
						cstb_next = 1'b0;
						txval_next = tally_reg;
						tally_next = 16'h0000;
						tx_next = GTCD_TX_DIGIT;
						txidx_next = `GTCD_DIG_TOP;
						lead_next = 1'b0;
					end
					`GTCD_SA_ERROR: begin
						cmd_next = GTCD_CMD_OTHER;
						cstb_next = 1'b0;
						txval_next = {8'h00, err_reg};
						err_next = 8'h00;
						srq_next = 1'b0;
						tx_next = GTCD_TX_DIGIT;
						txidx_next = `GTCD_DIG_TOP;
						lead_next = 1'b0;
					end
					default: cmd_next = GTCD_CMD_OTHER;
				endcase
			end
		end else if (byte_stb_i && listen_reg) begin
			dstb_next = 1'b1;
			data_next = byte_i;
		end
		// Refill the output slot when empty or just taken; most significant digit first
		if ((!txv_reg || tx_ready_i) && !untalk_now) begin
			txv_next = 1'b0;
			if (tx_reg == GTCD_TX_CR && talk_reg) begin
				txb_next = `GTCD_CR;
				txv_next = 1'b1;
				tx_next = GTCD_TX_IDLE;
			end else if (tx_reg == GTCD_TX_DIGIT && talk_reg) begin
				txval_next = rem_q;
				if (txidx_reg == 3'h0)
					tx_next = GTCD_TX_CR;
				else
					txidx_next = txidx_reg - 3'h1;
				// Leading zeros are skipped, a lone zero is still sent
				if (dig_q != 16'h0000 || lead_reg || txidx_reg == 3'h0) begin
					txb_next = `GTCD_ASCII_0 + dig_q[7:0];
					txv_next = 1'b1;
					lead_next = 1'b1;
				end
			end
		end
		// Record checking and retries
		if (bad_sum) begin
			tally_next = tally_next + 16'h0001;
			if (tries_reg + 4'h1 >= `GTCD_MAX_TRIES) begin
				srq_next = 1'b1;
				tries_next = 4'h0;
			end else begin
				tries_next = tries_reg + 4'h1;
				reread_next = 1'b1;
			end
		end else if (rec_done_i)
			tries_next = 4'h0;
		if (err_set_i) begin
			err_next = err_code_i;
			srq_next = 1'b1;
		end
	end

	// Register the decoder state
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			listen_reg <= 1'b0;
			talk_reg <= 1'b0;
			spoll_reg <= 1'b0;
			prim_reg <= 1'b0;
			srq_reg <= 1'b0;
			reread_reg <= 1'b0;
			parse_reg <= 1'b0;
			dstb_reg <= 1'b0;
			data_reg <= 8'h00;
			cstb_reg <= 1'b0;
			cmd_reg <= GTCD_CMD_NONE;
			eof_reg <= 1'b0;
			tries_reg <= 4'h0;
			tally_reg <= 16'h0000;
			err_reg <= 8'h00;
			tx_reg <= GTCD_TX_IDLE;
			txval_reg <= 16'h0000;
			txb_reg <= 8'h00;
			txv_reg <= 1'b0;
			txidx_reg <= 3'h0;
			lead_reg <= 1'b0;
		end else if (ce_i) begin
			listen_reg <= listen_next;
			talk_reg <= talk_next;
			spoll_reg <= spoll_next;
			prim_reg <= prim_next;
			srq_reg <= srq_next;
			reread_reg <= reread_next;
			parse_reg <= parse_next;
			dstb_reg <= dstb_next;
			data_reg <= data_next;
			cstb_reg <= cstb_next;
			cmd_reg <= cmd_next;
			eof_reg <= eof_next;
			tries_reg <= tries_next;
			tally_reg <= tally_next;
			err_reg <= err_next;
			tx_reg <= tx_next;
			txval_reg <= txval_next;
			txb_reg <= txb_next;
			txv_reg <= txv_next;
			txidx_reg <= txidx_next;
			lead_reg <= lead_next;
		end
	end

	// Outputs straight from flip-flops
	assign listen_o = listen_reg;
	assign talk_o = talk_reg;
	assign spoll_o = spoll_reg;
	assign srq_o = srq_reg;
	assign reread_o = reread_reg;
	assign parse_o = parse_reg;
	assign data_stb_o = dstb_reg;
	assign data_o = data_reg;
	assign cmd_o = cmd_reg;
	assign cmd_stb_o = cstb_reg;
	assign eof_wr_o = eof_reg;
	assign tx_valid_o = txv_reg;
	assign tx_byte_o = txb_reg;
	assign tally_o = tally_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i || !ce_i);

	sequence s_unl;
		atn_i && byte_stb_i && byte_i == `GTCD_UNL;
	endsequence
	sequence s_own_listen;
		atn_i && byte_stb_i && byte_i == mla;
	endsequence

	a_untalk_stops: assert property ((atn_i && byte_stb_i && byte_i == `GTCD_UNT) |=> !talk_o)
		else $error("untalk did not stop talker");
	a_unlisten_parse: assert property ((s_unl and listen_o) |=> parse_o && !listen_o)
		else $error("unlisten did not parse");
	a_spe_enter: assert property ((atn_i && byte_stb_i && byte_i == `GTCD_SPE) |=> spoll_o)
		else $error("poll enable not taken");
	a_spd_leave: assert property ((atn_i && byte_stb_i && byte_i == `GTCD_SPD) |=> !spoll_o)
		else $error("poll disable not taken");
	a_verb_ignore: assert property (!host_mode_i |=> !cmd_stb_o)
		else $error("secondary decoded in verb mode");
	a_unaddr_quiet: assert property ((!listen_o && !atn_i) |=> !data_stb_o)
		else $error("data taken while unaddressed");
	a_close_eof: assert property ((s_own_listen ##1 (own_sec && byte_i == 8'h62)) |=> eof_wr_o)
		else $error("close did not write mark");
	a_tally_count: assert property ((bad_sum && !own_sec && tally_o != 16'hffff)
		|=> tally_o == $past(tally_o) + 16'h0001)
		else $error("tally not incremented");
	a_srq_retries: assert property ((bad_sum && tries_reg == 4'h9) |=> srq_o)
		else $error("no request after ten tries");
	a_ren_ignored: assert property ($changed(ren_i) && !byte_stb_i && !rec_done_i && !err_set_i
		&& tx_reg == GTCD_TX_IDLE |=> $stable(listen_o) && $stable(talk_o))
		else $error("remote enable changed state");
	a_tx_hold: assert property ((tx_valid_o && !tx_ready_i && !untalk_now)
		|=> tx_valid_o && $stable(tx_byte_o))
		else $error("talked byte dropped before taken");
endmodule : gtcd_decoder
`default_nettype wire

// *** src/gtcd_pkg.sv ***
// Types for the bus command decoder of the tape drive
package gtcd_pkg;
	typedef enum logic [3:0] {
		GTCD_CMD_NONE = 4'h0,
		GTCD_CMD_CLOSE = 4'h1,
		GTCD_CMD_PROGRAM_READOUT = 4'h2,
		GTCD_CMD_HEADER = 4'h3,
		GTCD_CMD_INPUT = 4'h4,
		GTCD_CMD_FIND = 4'h5,
		GTCD_CMD_OTHER = 4'h6
	} gtcd_cmd_type;

	typedef enum logic [1:0] {
		GTCD_TX_IDLE = 2'b00,
		GTCD_TX_DIGIT = 2'b01,
		GTCD_TX_CR = 2'b11
	} gtcd_tx_type;
endpackage : gtcd_pkg

// *** testbench/gtcd_ctrl_model.sv ***
// Bus controller model: sends bytes under attention and takes talked bytes
`timescale 1ns/1ps
`default_nettype none

module gtcd_ctrl_model (
	input wire logic mclk_i,
	output logic byte_stb_o,
	output logic [7:0] byte_o,
	output logic atn_o,
	output logic tx_ready_o
);
	initial begin
		byte_stb_o = 1'b0;
		byte_o = 8'h00;
		atn_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// Consumer stalls at random
	always @(negedge mclk_i) begin
		tx_ready_o <= 1'($urandom_range(1, 0));
	end
	// One byte per strobe; called at a falling edge, strobe held across calls
	task send(input logic atn, input logic [7:0] b);
		atn_o = atn;
		byte_o = b;
		byte_stb_o = 1'b1;
		@(negedge mclk_i);
	endtask : send
	// Release: data lines show the inverse of the last byte
	task idle();
		byte_stb_o = 1'b0;
		byte_o = ~byte_o;
		atn_o = 1'b0;
		repeat (3) @(negedge mclk_i);
	endtask : idle
endmodule : gtcd_ctrl_model
`default_nettype wire

// *** testbench/gtcd_decoder_bench.sv ***
// Self-checking bench for the bus command decoder
`timescale 1ns/1ps
`default_nettype none

module gtcd_decoder_bench;
	import gtcd_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [4:0] dev = 5'h00;
	logic host = 1'b1, ren = 1'b0, rdone = 1'b0, eset = 1'b0;
	logic [7:0] rsum = 8'h00, rchk = 8'h00, ecode = 8'h00;
	logic stb, atn, txr, lis, talk, spoll, srq, rr, parse, dstb, cstb, eofw, txv;
	logic [7:0] bt, dout, txb, ldata;
	logic [15:0] tally;
	gtcd_cmd_type cmd, lcmd;
	int fails = 0, num_checks = 0;
	int n_cmd = 0, n_eof = 0, n_par = 0, n_dat = 0, n_rr = 0, m_tally = 0, m_tries = 0;
	logic [7:0] txq[$], expq[$];
	logic [4:0] sa_tab[5] = '{5'h02, 5'h04, 5'h09, 5'h0d, 5'h1b};
	gtcd_cmd_type ce_tab[5] = '{GTCD_CMD_CLOSE, GTCD_CMD_PROGRAM_READOUT, GTCD_CMD_HEADER,
		GTCD_CMD_INPUT, GTCD_CMD_FIND};

	always #4 mclk_i = ~mclk_i;
	// Remote enable wanders; nothing may follow it
	always @(negedge mclk_i) ren <= 1'($urandom_range(1, 0));

	gtcd_ctrl_model u_gtcd_ctrl_model (.mclk_i(mclk_i), .byte_stb_o(stb), .byte_o(bt),
		.atn_o(atn), .tx_ready_o(txr));
	gtcd_decoder u_gtcd_decoder (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.dev_addr_i(dev), .host_mode_i(host), .ren_i(ren), .byte_stb_i(stb), .byte_i(bt),
		.atn_i(atn), .rec_done_i(rdone), .rec_sum_i(rsum), .rec_chk_i(rchk),
		.err_code_i(ecode), .err_set_i(eset), .tx_ready_i(txr), .listen_o(lis), .talk_o(talk),
		.spoll_o(spoll), .srq_o(srq), .reread_o(rr), .parse_o(parse), .data_stb_o(dstb),
		.data_o(dout), .cmd_o(cmd), .cmd_stb_o(cstb), .eof_wr_o(eofw), .tx_valid_o(txv),
		.tx_byte_o(txb), .tally_o(tally));

	// Pulse counters and captured output
	always @(posedge mclk_i) begin
		n_cmd += (cstb === 1'b1);
		n_eof += (eofw === 1'b1);
		n_par += (parse === 1'b1);
		n_rr += (rr === 1'b1);
		if (cstb === 1'b1) lcmd = cmd;
		if (dstb === 1'b1) begin
			n_dat++;
			ldata = dout;
		end
		if (txv === 1'b1 && txr === 1'b1) txq.push_back(txb);
	end

	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task rec(input logic bad);
		int r0;
		r0 = n_rr;
		rsum = 8'($urandom);
		rchk = bad ? ~rsum : rsum;
		rdone = 1'b1;
		@(negedge mclk_i);
		rdone = 1'b0;
		repeat (3) @(negedge mclk_i);
		m_tries = bad ? m_tries + 1 : 0;
		m_tally += bad;
		check("reread", 16'(n_rr - r0), 16'(bad && m_tries < 10));
		if (m_tries == 10) begin
			check("srq", srq, 1'b1);
			m_tries = 0;
		end
	endtask : rec

	task query(input logic [7:0] sa, input int v);
		int k;
		txq.delete();
		expq.delete();
		do begin
			expq.push_front(8'(8'h30 + v % 10));
			v = v / 10;
		end while (v > 0);
		expq.push_back(8'h0d);
		u_gtcd_ctrl_model.send(1'b1, 8'h40 + dev);
		u_gtcd_ctrl_model.send(1'b1, sa);
		u_gtcd_ctrl_model.idle();
		check("talk", talk, 1'b1);
		for (k = 0; k < 500 && txq.size() < expq.size(); k++) @(negedge mclk_i);
		check("txn", 16'(txq.size()), 16'(expq.size()));
		for (int i = 0; i < txq.size() && i < expq.size(); i++) check("tx", txq[i], expq[i]);
		u_gtcd_ctrl_model.send(1'b1, 8'h5f);
		u_gtcd_ctrl_model.idle();
		check("untalk", talk, 1'b0);
	endtask : query

	// Watchdog
	initial begin
		#(8 * 40000);
		fails++;
		end_sim();
	end

	initial begin
		logic [7:0] d;
		int c0, e0;
		void'($urandom(10));
		dev = 5'($urandom_range(30, 0));
		repeat (20) @(negedge mclk_i);
		resetn_i = 1'b1;
		@(negedge mclk_i);
		for (int i = 0; i < 5; i++) begin
			c0 = n_cmd;
			e0 = n_eof;
			u_gtcd_ctrl_model.send(1'b1, 8'h20 + dev);
			u_gtcd_ctrl_model.send(1'b1, 8'h60 + sa_tab[i]);
			u_gtcd_ctrl_model.idle();
			check("listen", lis, 1'b1);
			check("ncmd", 16'(n_cmd - c0), 16'h0001);
			check("cmd", lcmd, ce_tab[i]);
			check("eof", 16'(n_eof - e0), 16'(i == 0));
			c0 = n_par;
			u_gtcd_ctrl_model.send(1'b1, 8'h3f);
			u_gtcd_ctrl_model.idle();
			check("parse", 16'(n_par - c0), 16'h0001);
			check("unlisten", lis, 1'b0);
		end
		$display("test commands done");
		host = 1'b0;
		c0 = n_cmd;
		e0 = n_dat;
		d = 8'($urandom);
		u_gtcd_ctrl_model.send(1'b1, 8'h20 + dev);
		u_gtcd_ctrl_model.send(1'b1, 8'h62);
		u_gtcd_ctrl_model.send(1'b0, d);
		u_gtcd_ctrl_model.idle();
		check("verb", 16'(n_cmd - c0), 16'h0000);
		check("data", ldata, d);
		u_gtcd_ctrl_model.send(1'b1, 8'h3f);
		u_gtcd_ctrl_model.send(1'b0, 8'($urandom));
		u_gtcd_ctrl_model.idle();
		check("ndata", 16'(n_dat - e0), 16'h0001);
		host = 1'b1;
		u_gtcd_ctrl_model.send(1'b1, 8'h20 + (dev == 5'd30 ? 5'd0 : dev + 5'd1));
		u_gtcd_ctrl_model.send(1'b1, 8'h62);
		u_gtcd_ctrl_model.send(1'b1, 8'h3f);
		u_gtcd_ctrl_model.idle();
		check("other", 16'(n_cmd - c0), 16'h0000);
		$display("test refusals done");
		u_gtcd_ctrl_model.send(1'b1, 8'h18);
		u_gtcd_ctrl_model.idle();
		check("spe", spoll, 1'b1);
		u_gtcd_ctrl_model.send(1'b1, 8'h19);
		u_gtcd_ctrl_model.idle();
		check("spd", spoll, 1'b0);
		$display("test poll done");
		repeat (3) rec(1'b1);
		rec(1'b0);
		repeat (10) rec(1'b1);
		check("tally", tally, 16'(m_tally));
		query(8'h78, m_tally);
		check("cleared", tally, 16'h0000);
		$display("test tally done");
		ecode = 8'h0c;
		eset = 1'b1;
		@(negedge mclk_i);
		eset = 1'b0;
		query(8'h7e, 12);
		check("srqclr", srq, 1'b0);
		$display("test error done");
		end_sim();
	end
endmodule : gtcd_decoder_bench
`default_nettype wire
